//--- src/lcd_instruction_decoder.sv
`timescale 1ns/1ps
`include "lcd_dec_cfg.svh"
module lcd_instruction_decoder
(
   input  wire logic                 clk_sys_in,         // 200 MHz
   input  wire logic                 rst_n_in,           // async reset
   input  wire logic                 hw_reset_pin_n_in,  // reset pin
   input  wire logic                 serial_in,          // serial mode
   input  wire logic                 cs_n_in,            // chip select
   input  wire logic                 cmd_data_select_in, // 0 command
   input  wire logic                 rd_n_in,            // read strobe
   input  wire logic                 wr_n_in,            // write strobe
   input  wire logic [7:0]           d_in,               // data bus in
   input  wire logic                 sclk_in,            // serial clock
   input  wire logic                 sdi_in,             // serial data
   output logic      [7:0]           d_out,              // data bus out
   output logic                      d_oe_out,           // bus drive
   output logic      [2:0]           page_out,           // page address
   output logic      [7:0]           col_out,            // column addr
   output logic                      rmw_out,            // rmw active
   output logic                      dreq_clr_out,       // request clr
   output logic                      vdrive_set_out,     // drive set
   output lcd_dec_pkg::disp_cfg_t    cfg_out             // settings
);
   lcd_dec_pkg::bus_cycle_t cyc;
   logic [1:0] pin_s;
   logic       soft_rst;
   logic [3:0] init_cnt_q;
   logic       psave_arm_q;
   logic [7:0] save_col_q;
   logic [7:0] rdata;
   logic [7:0] c;
   logic       col_step;
   logic [1:0] oe_rd_s;
   logic [1:0] oe_cs_s;
   logic [1:0] oe_ser_s;

   // all checks run on the system clock and sleep in reset
   default clocking cb_sys @(posedge clk_sys_in);
   endclocking
   default disable iff (!rst_n_in);

   // ---------------------------------------------------------------
   // front end and storage
   // ---------------------------------------------------------------
   lcd_bus_frontend u_fe
   (
      .clk_sys_in         (clk_sys_in),
      .rst_n_in           (rst_n_in),
      .serial_in          (serial_in),
      .cs_n_in            (cs_n_in),
      .cmd_data_select_in (cmd_data_select_in),
      .rd_n_in            (rd_n_in),
      .wr_n_in            (wr_n_in),
      .d_in               (d_in),
      .sclk_in            (sclk_in),
      .sdi_in             (sdi_in),
      .ser_clr_in         (!pin_s[1]),
      .cyc_out            (cyc)
   );

   lcd_ram u_ram
   (
      .clk_sys_in (clk_sys_in),
      .we_in      (cyc.data_wr),
      .page_in    (page_out),
      .col_in     (col_out),
      .wdata_in   (cyc.data),
      .rdata_out  (rdata)
   );

   assign c = cyc.data;

   // column step: any data access; reads frozen in rmw mode
   always_comb
   begin
      col_step = cyc.data_wr || (cyc.data_rd && !rmw_out);
   end

   // soft reset command
   assign soft_rst = cyc.cmd_wr && c == `CMD_RESET;

   // ---------------------------------------------------------------
   // hardware reset pin
   // ---------------------------------------------------------------
   // pin is asynchronous; two flops before use
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
      if (!rst_n_in)
         pin_s <= 2'h0;
      else
         pin_s <= {pin_s[0], hw_reset_pin_n_in};

   // init period counter, restarted by pin or command
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
      if (!rst_n_in)
         init_cnt_q <= `INIT_CYCLES;
      else if (!pin_s[1] || soft_rst)
         init_cnt_q <= `INIT_CYCLES;
      else if (init_cnt_q != 4'h0)
         init_cnt_q <= init_cnt_q - 4'h1;

   // ---------------------------------------------------------------
   // address counters
   // ---------------------------------------------------------------
   // page only changes on its own command or a reset, never by auto step
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
      if (!rst_n_in)
         page_out <= 3'h0;
      else if (!pin_s[1] || soft_rst)
         page_out <= 3'h0;
      else if (cyc.cmd_wr && c[7:4] == 4'hB && c[2:0] <= `PAGE_MAX)
         page_out <= c[2:0];

   // column: nibble loads, auto step saturating at the top count
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
      if (!rst_n_in)
         col_out <= 8'h00;
      else if (!pin_s[1] || soft_rst)
         col_out <= 8'h00;
      else if (cyc.cmd_wr && c[7:4] == 4'h1)
         col_out <= {c[3:0], col_out[3:0]};
      else if (cyc.cmd_wr && c[7:4] == 4'h0)
         col_out <= {col_out[7:4], c[3:0]};
      else if (cyc.cmd_wr && c == `CMD_RMW_END && rmw_out)
         col_out <= save_col_q;
      else if (col_step && col_out != `COL_MAX)
         col_out <= col_out + 8'h01;

   // read-modify-write mode and saved column
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
      if (!rst_n_in)
      begin
         rmw_out <= 1'b0;
         save_col_q <= 8'h00;
      end
      else if (!pin_s[1])
         rmw_out <= 1'b0;
      else if (cyc.cmd_wr && c == `CMD_RMW_ON)
      begin
         rmw_out <= 1'b1;
         save_col_q <= col_out;
      end
      else if (cyc.cmd_wr && c == `CMD_RMW_END)
         rmw_out <= 1'b0;

   // ---------------------------------------------------------------
   // display settings
   // ---------------------------------------------------------------
   // pin reset clears all; command reset only address, scroll size, speed and page mask, contrast and common order
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
      if (!rst_n_in)
         cfg_out <= '0;
      else if (!pin_s[1])
         cfg_out <= '0;
      else if (soft_rst)
      begin
         cfg_out.common_order_bit <= 1'b0;
         cfg_out.contrast_level <= `CONTRAST_RST;
         cfg_out.scroll_big <= 1'b0;
         cfg_out.scroll_speed_bits <= `SCROLL_SPD_RST;
         cfg_out.scroll_page_mask <= `MASK_RST;
      end
      else if (cyc.cmd_wr)
      begin
         // undefined patterns fall through with no effect
         if (c[7:1] == 7'h57)
            cfg_out.display_on <= c[0];
         if (c[7:1] == 7'h50)
            cfg_out.seg_reverse <= c[0];
         if (c[7:1] == 7'h53)
            cfg_out.pix_inverse <= c[0];
         if (c[7:1] == 7'h53 && !c[0])
            cfg_out.power_save <= 1'b0;
         if (c[7:1] == 7'h52)
         begin
            cfg_out.all_on <= c[0];
            if (c[0] && (!cfg_out.display_on || psave_arm_q))
               cfg_out.power_save <= 1'b1;
         end
         if (c[7:1] == 7'h55)
            cfg_out.icon_duty <= c[0];
         if (c[7:1] == 7'h12)
            cfg_out.supply_on <= c[0];
         if (c[7:1] == 7'h54)
            cfg_out.scroll_on <= c[0];
         if (c[7:4] == 4'hC)
         begin
            cfg_out.common_order_bit <= c[3];
            cfg_out.scroll_big <= c[2];
            cfg_out.scroll_speed_bits <= c[1:0];
         end
         if (c[7:5] == 3'h4)
            cfg_out.contrast_level <= c[4:0];
         if (c[7:6] == 2'h1)
            cfg_out.scroll_page_mask <= c[3:0];
      end

   // first half of the two-byte power save command
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
      if (!rst_n_in)
         psave_arm_q <= 1'b0;
      else if (!pin_s[1])
         psave_arm_q <= 1'b0;
      else if (cyc.cmd_wr)
         psave_arm_q <= (c == `CMD_PSAVE_1);

   // one-cycle strobes for outside circuits
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
      if (!rst_n_in)
      begin
         dreq_clr_out <= 1'b0;
         vdrive_set_out <= 1'b0;
      end
      else
      begin
         dreq_clr_out <= cyc.cmd_wr && c == `CMD_DREQ_CLR;
         vdrive_set_out <= cyc.cmd_wr && c == `CMD_VDRIVE;
      end

   // ---------------------------------------------------------------
   // read data path
   // ---------------------------------------------------------------
   // driver gating reads pins, so sync them first
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
      if (!rst_n_in)
      begin
         oe_rd_s <= 2'h3;
         oe_cs_s <= 2'h3;
         oe_ser_s <= 2'h0;
      end
      else
      begin
         oe_rd_s <= {oe_rd_s[0], rd_n_in};
         oe_cs_s <= {oe_cs_s[0], cs_n_in};
         oe_ser_s <= {oe_ser_s[0], serial_in};
      end

   // busy never asserts: every command retires in one cycle
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
      if (!rst_n_in)
      begin
         d_out <= 8'h00;
         d_oe_out <= 1'b0;
      end
      else
      begin
         d_oe_out <= !oe_rd_s[1] && !oe_cs_s[1] && !oe_ser_s[1];
         if (cyc.stat_rd)
            d_out <= {1'b0, !cfg_out.seg_reverse,
                      !cfg_out.display_on,
                      init_cnt_q != 4'h0, 4'h0};
         else if (cyc.data_rd)
            d_out <= rdata;
      end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   AST_PAGE_HOLD: assert property (
      (cyc.data_wr && pin_s[1]) |=> $stable(page_out))
      else $error("page moved");
   AST_COL_STEP: assert property (
      (cyc.data_wr && !cyc.cmd_wr && col_out < 8'h9F && pin_s[1])
      |=> col_out == $past(col_out) + 8'h01)
      else $error("no step");
   AST_RMW_READ: assert property (
      (cyc.data_rd && rmw_out && pin_s[1]) |=> $stable(col_out))
      else $error("rmw read moved column");
   AST_STAT_DIR: assert property (
      cyc.stat_rd |=> d_out[6] == !$past(cfg_out.seg_reverse)
      && d_out[3:0] == 4'h0)
      else $error("status bad");
   AST_INIT_FLAG: assert property (
      soft_rst |=> init_cnt_q != 4'h0)
      else $error("no init");
   AST_RESET_CMD: assert property (
      (soft_rst && pin_s[1]) |=> col_out == 8'h00 && page_out == 3'h0)
      else $error("reset cmd");
   AST_DISP_ON: assert property (
      (cyc.cmd_wr && c == 8'hAF && pin_s[1]) |=> cfg_out.display_on)
      else $error("display on");
   AST_PSAVE: assert property (
      (cyc.cmd_wr && c == 8'hA5 && !cfg_out.display_on && pin_s[1])
      |=> cfg_out.power_save)
      else $error("no power save");
   AST_PAGE_LIMIT: assert property (
      (cyc.cmd_wr && c[7:4] == 4'hB && c[2:0] > `PAGE_MAX && pin_s[1])
      |=> $stable(page_out))
      else $error("page above four taken");
   AST_READ_STEP: assert property (
      (cyc.data_rd && !rmw_out && col_out != `COL_MAX && pin_s[1])
      |=> col_out == $past(col_out) + 8'h01)
      else $error("read did not step");
   AST_RMW_END: assert property (
      (cyc.cmd_wr && c == `CMD_RMW_END && rmw_out && pin_s[1])
      |=> col_out == save_col_q && !rmw_out)
      else $error("column not restored");
   AST_STAT_FIXED: assert property (
      cyc.stat_rd |=> d_out[7] == 1'b0
      && d_out[5] == !$past(cfg_out.display_on))
      else $error("busy or display flag wrong");
   AST_INIT_PIN: assert property (
      !pin_s[1] |=> init_cnt_q == `INIT_CYCLES)
      else $error("init not restarted");
   AST_VDRIVE: assert property (
      (cyc.cmd_wr && c == `CMD_VDRIVE) |=> vdrive_set_out && !dreq_clr_out)
      else $error("drive pulse missing");
   AST_UNDEF: assert property (
      (cyc.cmd_wr && c[7:4] == 4'hF && pin_s[1])
      |=> $stable(cfg_out) && $stable(col_out) && $stable(page_out))
      else $error("undefined command took effect");
endmodule

//--- src/lcd_dec_cfg.svh
`ifndef LCD_DEC_CFG_SVH
`define LCD_DEC_CFG_SVH
`define COL_MAX        8'h00_A0
`define PAGE_MAX       3'h4
`define RAM_COLS       8'h00_A1
`define INIT_CYCLES    4'h8
`define SCROLL_SPD_RST 2'h0
`define CONTRAST_RST   5'h00
`define MASK_RST       4'h0
`define CMD_RMW_ON     8'hE0
`define CMD_RMW_END    8'hEE
`define CMD_RESET      8'hE2
`define CMD_VDRIVE     8'hED
`define CMD_DREQ_CLR   8'h20
`define CMD_PSAVE_1    8'hAE
`define CMD_PSAVE_2    8'hA5
`endif

//--- src/lcd_dec_pkg.sv
package lcd_dec_pkg;
   // one decoded host bus cycle
   typedef struct packed {
      logic       cmd_wr;
      logic       stat_rd;
      logic       data_wr;
      logic       data_rd;
      logic [7:0] data;
   } bus_cycle_t;
   // display settings seen by the drive logic
   typedef struct packed {
      logic       display_on;
      logic       seg_reverse;
      logic       pix_inverse;
      logic       all_on;
      logic       icon_duty;
      logic       supply_on;
      logic       power_save;
      logic       scroll_on;
      logic       common_order_bit;
      logic       scroll_big;
      logic [1:0] scroll_speed_bits;
      logic [4:0] contrast_level;
      logic [3:0] scroll_page_mask;
   } disp_cfg_t;
endpackage

//--- src/lcd_bus_frontend.sv
`timescale 1ns/1ps
`include "lcd_dec_cfg.svh"
module lcd_bus_frontend
(
   input  wire logic                    clk_sys_in,   // system clock
   input  wire logic                    rst_n_in,     // async reset
   input  wire logic                    serial_in,    // serial mode select
   input  wire logic                    cs_n_in,      // chip select
   input  wire logic                    cmd_data_select_in, // 0 cmd
   input  wire logic                    rd_n_in,      // read strobe
   input  wire logic                    wr_n_in,      // write strobe
   input  wire logic [7:0]              d_in,         // parallel data
   input  wire logic                    sclk_in,      // serial clock
   input  wire logic                    sdi_in,       // serial data
   input  wire logic                    ser_clr_in,   // clear shifter
   output lcd_dec_pkg::bus_cycle_t      cyc_out       // decoded cycle
);
   logic [1:0] s_cs, s_a0, s_rd, s_wr, s_sck, s_sd, s_ser;
   logic [7:0] s_d0, s_d1;
   logic       rd_p, wr_p, sck_p;
   logic [7:0] sh_q;
   logic [2:0] cnt_q;
   // ---------------------------------------------------------------
   // synchronisers
   // ---------------------------------------------------------------
   // pins are async to clk; two stages before any use
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
      if (!rst_n_in)
      begin
         s_cs <= 2'h3;
         s_a0 <= 2'h0;
         s_rd <= 2'h3;
         s_wr <= 2'h3;
         s_sck <= 2'h0;
         s_sd <= 2'h0;
         s_ser <= 2'h0;
         s_d0 <= 8'h00;
         s_d1 <= 8'h00;
      end
      else
      begin
         s_cs <= {s_cs[0], cs_n_in};
         s_a0 <= {s_a0[0], cmd_data_select_in};
         s_rd <= {s_rd[0], rd_n_in};
         s_wr <= {s_wr[0], wr_n_in};
         s_sck <= {s_sck[0], sclk_in};
         s_sd <= {s_sd[0], sdi_in};
         s_ser <= {s_ser[0], serial_in};    // mode strap is a pin too
         s_d0 <= d_in;
         s_d1 <= s_d0;
      end
   // edge history on synchronised copies only
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
      if (!rst_n_in)
      begin
         rd_p <= 1'b1;
         wr_p <= 1'b1;
         sck_p <= 1'b0;
      end
      else
      begin
         rd_p <= s_rd[1];
         wr_p <= s_wr[1];
         sck_p <= s_sck[1];
      end
   // ---------------------------------------------------------------
   // serial shifter, msb first
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
      if (!rst_n_in)
      begin
         sh_q <= 8'h00;
         cnt_q <= 3'h0;
      end
      else if (ser_clr_in || s_cs[1])
         cnt_q <= 3'h0;
      else if (s_ser[1] && s_sck[1] && !sck_p)
      begin
         sh_q <= {sh_q[6:0], s_sd[1]};
         cnt_q <= cnt_q + 3'h1;
      end
   // ---------------------------------------------------------------
   // cycle classification on strobe rising edge, status reads on falling edge
   // ---------------------------------------------------------------
   // data is taken at strobe release, when the host has it stable
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
      if (!rst_n_in)
         cyc_out <= '0;
      else
      begin
         cyc_out <= '0;
         if (s_ser[1])
         begin
            if (!s_cs[1] && s_sck[1] && !sck_p && cnt_q == 3'h7)
            begin
               cyc_out.cmd_wr <= !s_a0[1];
               cyc_out.data_wr <= s_a0[1];
               cyc_out.data <= {sh_q[6:0], s_sd[1]};
            end
         end
         else if (!s_cs[1])
         begin
            cyc_out.cmd_wr <= !s_a0[1] && s_wr[1] && !wr_p;
            cyc_out.data_wr <= s_a0[1] && s_wr[1] && !wr_p;
            cyc_out.stat_rd <= !s_a0[1] && !s_rd[1] && rd_p;
            cyc_out.data_rd <= s_a0[1] && s_rd[1] && !rd_p;
            cyc_out.data <= s_d1;
         end
      end
endmodule

//--- src/lcd_ram.sv
`timescale 1ns/1ps
`include "lcd_dec_cfg.svh"
module lcd_ram
(
   input  wire logic       clk_sys_in,  // system clock
   input  wire logic       we_in,       // write enable
   input  wire logic [2:0] page_in,     // page index
   input  wire logic [7:0] col_in,      // column index
   input  wire logic [7:0] wdata_in,    // write byte
   output logic      [7:0] rdata_out    // byte at address
);
   logic [7:0] mem_q [0:5*161-1];
   logic [9:0] idx;
   // no reset: contents survive resets by design
   assign idx = 10'(page_in) * 10'd161 + 10'(col_in);
   always_ff @(posedge clk_sys_in)
      if (we_in)
         mem_q[idx] <= wdata_in;
   assign rdata_out = mem_q[idx];
endmodule

//--- tb/lcd_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// host processor model: parallel and serial bus master
// ----------------------------------------------------------------
module lcd_host_model
(
   input  wire logic       clk_sys_in,          // system clock
   input  wire logic [7:0] dev_data_in,         // device read data
   input  wire logic       dev_oe_in,           // device drives bus
   output logic            serial_out,          // serial mode level
   output logic            cs_n_out,            // chip select
   output logic            cmd_data_select_out, // 0 command
   output logic            rd_n_out,            // read strobe
   output logic            wr_n_out,            // write strobe
   output logic      [7:0] data_out,            // parallel data
   output logic            sclk_out,            // serial clock
   output logic            sdi_out              // serial data
);
   // idle bus at time zero, serial clock parked low
   initial
   begin
      serial_out          = 1'b0;
      cs_n_out            = 1'b1;
      cmd_data_select_out = 1'b0;
      rd_n_out            = 1'b1;
      wr_n_out            = 1'b1;
      data_out            = 8'h00;
      sclk_out            = 1'b0;
      sdi_out             = 1'b0;
   end
   // write cycle; strobe held well past the two-flop sync, and the
   // next strobe is spaced out so busy never needs polling
   task automatic bus_wr(input logic sel, input logic [7:0] b);
      @(posedge clk_sys_in);
      serial_out          <= 1'b0;
      cs_n_out            <= 1'b0;
      cmd_data_select_out <= sel;
      data_out            <= b;
      wr_n_out            <= 1'b0;
      repeat (5) @(posedge clk_sys_in);
      wr_n_out <= 1'b1;
      repeat (4) @(posedge clk_sys_in);
      cs_n_out <= 1'b1;
      data_out <= ~b; // released bus does not keep the last value
      repeat (4) @(posedge clk_sys_in);
   endtask
   // read cycle: status sampled while low, data after release
   task automatic bus_rd(input  logic       sel,
                         output logic [7:0] stat,
                         output logic [7:0] data,
                         output logic       oe);
      @(posedge clk_sys_in);
      serial_out          <= 1'b0;
      cs_n_out            <= 1'b0;
      cmd_data_select_out <= sel;
      rd_n_out            <= 1'b0;
      repeat (7) @(posedge clk_sys_in);
      #1;
      stat = dev_data_in;
      oe   = dev_oe_in;
      @(posedge clk_sys_in);
      rd_n_out <= 1'b1;
      repeat (4) @(posedge clk_sys_in);
      cs_n_out <= 1'b1;
      repeat (4) @(posedge clk_sys_in);
      #1;
      data = dev_data_in;
   endtask
   // serial byte, most significant bit first, clock still between
   task automatic ser_wr(input logic sel, input logic [7:0] b);
      @(posedge clk_sys_in);
      serial_out          <= 1'b1;
      cs_n_out            <= 1'b0;
      cmd_data_select_out <= sel;
      for (int i = 7; i >= 0; i--)
      begin
         sdi_out <= b[i];
         repeat (4) @(posedge clk_sys_in);
         sclk_out <= 1'b1;
         repeat (4) @(posedge clk_sys_in);
         sclk_out <= 1'b0;
      end
      repeat (8) @(posedge clk_sys_in);
      cs_n_out <= 1'b1;
      sdi_out  <= ~b[0];
      repeat (4) @(posedge clk_sys_in);
   endtask
endmodule

//--- tb/lcd_instruction_decoder_tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) \
   begin \
      checks++; \
      if ((g) !== (e)) \
      begin \
         miscompares++; \
         $display("[FAIL] %0t got %0h exp %0h", $time, g, e); \
      end \
   end
module lcd_instruction_decoder_tb_top;
   logic                   clk = 1'b0;
   logic                   rst_n = 1'b0;
   logic                   hw_n = 1'b1;
   logic                   serial, cs_n, sel, rd_n, wr_n, sclk, sdi;
   logic             [7:0] hd, dd, col;
   logic             [2:0] page;
   logic                   oe, rmw, dreq, vdset;
   lcd_dec_pkg::disp_cfg_t cfg, exp_cfg;
   logic             [2:0] ep;
   logic             [7:0] ec, saved;
   logic                   er;
   int                     ed, ev, n_dreq, n_vd;
   int                     checks, miscompares;
   // ----------------------------------------------------------------
   // clock, pulse counters, device and host
   // ----------------------------------------------------------------
   always #2.5 clk = ~clk;
   // pulses last one cycle, so count them on every edge
   always @(posedge clk)
   begin
      if (dreq === 1'b1) n_dreq++;
      if (vdset === 1'b1) n_vd++;
   end
   lcd_instruction_decoder u_dut (.clk_sys_in(clk), .rst_n_in(rst_n),
      .hw_reset_pin_n_in(hw_n), .serial_in(serial), .cs_n_in(cs_n),
      .cmd_data_select_in(sel), .rd_n_in(rd_n), .wr_n_in(wr_n),
      .d_in(hd), .sclk_in(sclk), .sdi_in(sdi), .d_out(dd),
      .d_oe_out(oe), .page_out(page), .col_out(col), .rmw_out(rmw),
      .dreq_clr_out(dreq), .vdrive_set_out(vdset), .cfg_out(cfg));
   lcd_host_model u_host (.clk_sys_in(clk), .dev_data_in(dd),
      .dev_oe_in(oe), .serial_out(serial), .cs_n_out(cs_n),
      .cmd_data_select_out(sel), .rd_n_out(rd_n), .wr_n_out(wr_n),
      .data_out(hd), .sclk_out(sclk), .sdi_out(sdi));
   // ----------------------------------------------------------------
   // expected state kept from the command codes alone
   // ----------------------------------------------------------------
   function automatic void apply(input logic [7:0] c);
      casez (c)
         8'b1010_111?: exp_cfg.display_on = c[0];
         8'b1010_000?: exp_cfg.seg_reverse = c[0];
         8'b1010_011?:
         begin
            exp_cfg.pix_inverse = c[0];
            if (!c[0]) exp_cfg.power_save = 1'b0;
         end
         8'b1010_010?:
         begin
            exp_cfg.all_on = c[0];
            if (c[0] && !exp_cfg.display_on) exp_cfg.power_save = 1'b1;
         end
         8'b1010_101?: exp_cfg.icon_duty = c[0];
         8'b1010_100?: exp_cfg.scroll_on = c[0];
         8'b0010_010?: exp_cfg.supply_on = c[0];
         8'b1100_????: {exp_cfg.common_order_bit, exp_cfg.scroll_big,
                        exp_cfg.scroll_speed_bits} = c[3:0];
         8'b100?_????: exp_cfg.contrast_level = c[4:0];
         8'b01??_????: exp_cfg.scroll_page_mask = c[3:0];
         8'b1011_????: if (c[2:0] <= 3'h4) ep = c[2:0];
         8'b0001_????: ec[7:4] = c[3:0];
         8'b0000_????: ec[3:0] = c[3:0];
         8'h20: ed++;
         8'hED: ev++;
         8'hE0: {er, saved} = {1'b1, ec};
         8'hEE: {er, ec} = {1'b0, saved};
         8'hE2:
         begin
            {ec, ep} = '0;
            {exp_cfg.common_order_bit, exp_cfg.scroll_big} = 2'b00;
            exp_cfg.scroll_speed_bits = 2'h0;
            exp_cfg.contrast_level    = 5'h00;
            exp_cfg.scroll_page_mask  = 4'h0;
         end
         default: ; // unknown codes leave everything alone
      endcase
   endfunction
   task automatic check_all();
      `CHK(cfg, exp_cfg)
      `CHK(page, ep)
      `CHK(col, ec)
      `CHK(rmw, er)
      `CHK(n_dreq, ed)
      `CHK(n_vd, ev)
   endtask
   task automatic stat(input logic init);
      logic [7:0] st, dt;
      logic       o;
      u_host.bus_rd(1'b0, st, dt, o);
      `CHK(st, {1'b0, ~exp_cfg.seg_reverse, ~exp_cfg.display_on, init,
                4'h0})
   endtask
   // the init flag restarts after a reset command, so skip that one
   task automatic cmd(input logic [7:0] c);
      u_host.bus_wr(1'b0, c);
      apply(c);
      check_all();
      if (c != 8'hE2) stat(1'b0);
   endtask
   task automatic dwr(input logic [7:0] b);
      u_host.bus_wr(1'b1, b);
      ec = ec + 8'h01;
      check_all();
   endtask
   task automatic drd(input logic chk, input logic [7:0] e);
      logic [7:0] st, dt;
      logic       o;
      u_host.bus_rd(1'b1, st, dt, o);
      if (!er) ec = ec + 8'h01;
      `CHK(o, 1'b1)
      if (chk) `CHK(dt, e)
      check_all();
   endtask
   task automatic tally_and_finish();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   logic [7:0] tbl [] = '{8'hAF, 8'hA1, 8'hA7, 8'hA5, 8'hA4, 8'hAB,
      8'h25, 8'hA9, 8'hCB, 8'hC4, 8'h9F, 8'h85, 8'h4A, 8'h7F, 8'h20,
      8'hED, 8'hB4, 8'hB5, 8'hB9, 8'h16, 8'h0F, 8'hF0, 8'hD5, 8'h30,
      8'h21, 8'hE2, 8'hA0, 8'hA6, 8'hAE, 8'hA5, 8'hA6, 8'hAA, 8'h24,
      8'hA8, 8'hAF};
   initial
   begin
      {exp_cfg, ep, ec, saved, er, ed, ev} = '0;
      {n_dreq, n_vd, checks, miscompares} = '0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      check_all();
      stat(1'b0);
      $display("test reset_values done");
      foreach (tbl[i]) cmd(tbl[i]);
      $display("test command_table done");
      // page 2 written, read back after one dummy read
      cmd(8'hB2);
      cmd(8'h11);
      cmd(8'h00);
      dwr(8'hAA);
      dwr(8'h55);
      dwr(8'hC3);
      cmd(8'h00);
      drd(1'b0, 8'h00);
      drd(1'b1, 8'h55);
      drd(1'b1, 8'hC3);
      cmd(8'h16);
      cmd(8'h0E);
      dwr(8'h11);
      dwr(8'h22);
      $display("test data_access done");
      // read-modify-write: reads hold the column, end restores it
      cmd(8'h12);
      cmd(8'h00);
      dwr(8'h5A);
      cmd(8'h00);
      cmd(8'hE0);
      drd(1'b0, 8'h00);
      drd(1'b1, 8'h5A);
      dwr(8'hA5);
      cmd(8'hEE);
      cmd(8'hE0);
      drd(1'b0, 8'h00);
      drd(1'b1, 8'hA5);
      cmd(8'hEE);
      $display("test read_modify_write done");
      // serial bytes: a reversed bit order would decode differently
      u_host.ser_wr(1'b0, 8'hB3);
      apply(8'hB3);
      check_all();
      u_host.ser_wr(1'b0, 8'hAE);
      apply(8'hAE);
      check_all();
      u_host.ser_wr(1'b1, 8'h3C);
      ec = ec + 8'h01;
      check_all();
      $display("test serial done");
      // reset pin clears settings and mode, flags init while low
      cmd(8'hAF);
      cmd(8'hE0);
      @(posedge clk);
      hw_n <= 1'b0;
      {exp_cfg, ep, ec, er} = '0;
      repeat (4) @(posedge clk);
      stat(1'b1);
      @(posedge clk);
      hw_n <= 1'b1;
      repeat (20) @(posedge clk);
      check_all();
      stat(1'b0);
      $display("test reset_pin done");
      tally_and_finish();
   end
   // watchdog: the tests need well under a fifth of this span
   initial
   begin
      #100_000;
      miscompares++;
      $display("[FAIL] %0t watchdog expired", $time);
      tally_and_finish();
   end
endmodule
